//--- fcc_pkg.sv
// Purpose: Shared constants, command codes and helpers for the flash card host controller
// Assumes: 250 MHz clock; card bus used byte-wide, one byte lane per command
// Notes:   Command addresses carry the chip bit on top of the unlock offsets
package fcc_pkg;

    localparam int CLK_MHZ         = 250;
    localparam int GLITCH_NS       = 5;
    localparam int STROBE_NS       = 40;
    localparam int SETUP_NS        = 8;
    localparam int HOLD_NS         = 8;
    localparam int RESET_LOW_NS    = 500;
    localparam int RESET_DONE_US   = 20;
    localparam int ERASE_WINDOW_US = 50;
    localparam int CNT_W           = 16;

    // Least times round up, never below one cycle
    function automatic int ceil_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int GLITCH_CYC    = ceil_cyc(GLITCH_NS);
    localparam int STROBE_CYC    = ceil_cyc(STROBE_NS);
    localparam int SETUP_CYC     = ceil_cyc(SETUP_NS);
    localparam int HOLD_CYC      = ceil_cyc(HOLD_NS);
    localparam int RESET_LOW_CYC = ceil_cyc(RESET_LOW_NS);

    localparam int          CHIP_BIT         = 21;
    localparam logic [21:0] CMD_ADDR_FIRST   = 22'h005555;
    localparam logic [21:0] CMD_ADDR_SECOND  = 22'h002AAA;
    localparam logic [21:0] IDENT_MAKER_OFS  = 22'h000000;
    localparam logic [21:0] IDENT_DEVICE_OFS = 22'h000001;

    localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
    localparam logic [7:0] CODE_RESET   = 8'hF0;
    localparam logic [7:0] CODE_IDENT   = 8'h90;
    localparam logic [7:0] CODE_PROGRAM = 8'hA0;
    localparam logic [7:0] CODE_ERASE   = 8'h80;
    localparam logic [7:0] CODE_SECTOR  = 8'h30;
    localparam logic [7:0] CODE_CHIP    = 8'h10;
    localparam logic [7:0] CODE_SUSPEND = 8'hB0;
    localparam logic [7:0] CODE_RESUME  = 8'h30;

    typedef enum logic [3:0] {
        OP_READ, OP_ID_MAKER, OP_ID_DEVICE, OP_RST_SHORT, OP_RST_LONG, OP_IDENT,
        OP_PROGRAM, OP_SECT_ERASE, OP_CHIP_ERASE, OP_SUSPEND, OP_RESUME, OP_HW_RESET
    } fcc_op_t;

    function automatic logic is_read(input fcc_op_t op);
        return (op == OP_READ) || (op == OP_ID_MAKER) || (op == OP_ID_DEVICE);
    endfunction

    function automatic logic [2:0] seq_len(input fcc_op_t op);
        case (op)
            OP_RST_LONG, OP_IDENT:       return 3'd3;
            OP_PROGRAM:                  return 3'd4;
            OP_SECT_ERASE, OP_CHIP_ERASE: return 3'd6;
            default:                     return 3'd1;
        endcase
    endfunction

endpackage

//--- fcc_sync.sv
// Purpose: Two-flop synchroniser for card pins and switch levels
// Assumes: Inputs are asynchronous to clock_in
// Notes:   Stage one feeds stage two only
`timescale 1ns/1ps
module fcc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock_in,
    input  wire logic         sys_rst_in,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // fcc_sync

//--- fcc_cycle.sv
// Purpose: Runs one card bus cycle: setup, strobe, hold
// Assumes: bus_in already synchronised; start only while idle
// Notes:   Strobe width is far above the card's glitch filter
`timescale 1ns/1ps
module fcc_cycle
    import fcc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    // Cycle request
    input  wire logic        start_in,
    input  wire logic        write_in,
    input  wire logic [21:0] addr_in,
    input  wire logic [7:0]  data_in,
    input  wire logic        lane_in,
    input  wire logic [15:0] bus_in,
    output logic             done_out,
    output logic [7:0]       rdata_out,
    // Card pins
    output logic [21:0]      card_addr_out,
    output logic             low_lane_select_n_out,
    output logic             high_lane_select_n_out,
    output logic             card_oe_n_out,
    output logic             card_we_n_out,
    output logic [15:0]      card_data_out,
    output logic [1:0]       card_data_oe_out
);
    typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fcc_phase_t;
    localparam int STRB_LEN = STROBE_CYC;

    fcc_phase_t phase_q;
    logic [7:0]  cnt_q;
    logic        write_q, lane_q, done_q, oe_n_q, we_n_q, lsel_n_q, hsel_n_q;
    logic [21:0] addr_q;
    logic [15:0] dq_q;
    logic [1:0]  dq_oe_q;
    logic [7:0]  rdata_q;
    wire         cnt_end = (cnt_q == 8'h00);

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            phase_q <= E_IDLE;
            cnt_q <= 8'h00;
            write_q <= 1'b0;
            lane_q <= 1'b0;
            done_q <= 1'b0;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            lsel_n_q <= 1'b1;
            hsel_n_q <= 1'b1;
            addr_q <= 22'h000000;
            dq_q <= 16'h0000;
            dq_oe_q <= 2'b00;
            rdata_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            if (!cnt_end) begin
                cnt_q <= cnt_q - 8'h01;
            end
            case (phase_q)
                E_IDLE: if (start_in) begin
                    // Only the lane named by lane_in is selected; the other lane idles
                    phase_q <= E_SETUP;
                    cnt_q <= 8'(SETUP_CYC - 1);
                    write_q <= write_in;
                    lane_q <= lane_in;
                    addr_q <= addr_in;
                    lsel_n_q <= lane_in;
                    hsel_n_q <= !lane_in;
                    dq_q <= lane_in ? {data_in, 8'h00} : {8'h00, data_in};
                    dq_oe_q <= write_in ? {lane_in, !lane_in} : 2'b00;
                end
                E_SETUP: if (cnt_end) begin
                    phase_q <= E_STROBE;
                    cnt_q <= 8'(STROBE_CYC - 1);
                    we_n_q <= !write_q;
                    oe_n_q <= write_q;
                end
                E_STROBE: if (cnt_end) begin
                    phase_q <= E_HOLD;
                    cnt_q <= 8'(HOLD_CYC - 1);
                    we_n_q <= 1'b1;
                    oe_n_q <= 1'b1;
                    if (!write_q) begin
                        rdata_q <= lane_q ? bus_in[15:8] : bus_in[7:0];
                    end
                end
                E_HOLD: if (cnt_end) begin
                    // Back to inactive levels between cycles
                    phase_q <= E_IDLE;
                    lsel_n_q <= 1'b1;
                    hsel_n_q <= 1'b1;
                    dq_oe_q <= 2'b00;
                    done_q <= 1'b1;
                end
                default: phase_q <= E_IDLE;
            endcase
        end
    end

    assign done_out = done_q;
    assign rdata_out = rdata_q;
    assign card_addr_out = addr_q;
    assign low_lane_select_n_out = lsel_n_q;
    assign high_lane_select_n_out = hsel_n_q;
    assign card_oe_n_out = oe_n_q;
    assign card_we_n_out = we_n_q;
    assign card_data_out = dq_q;
    assign card_data_oe_out = dq_oe_q;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    strobe_min_a: assert property ($fell(we_n_q) |-> !we_n_q [*8])
        else $error("write strobe shorter than minimum");
    strobe_len_a: assert property ($fell(we_n_q) |-> ##[STRB_LEN:STRB_LEN] $rose(we_n_q))
        else $error("write strobe length wrong");
    oe_we_excl_a: assert property (!(!oe_n_q && !we_n_q))
        else $error("output and write enable low together");
    strobe_data_a: assert property (!we_n_q |-> (dq_oe_q != 2'b00) && (lsel_n_q != hsel_n_q))
        else $error("write strobe without driven lane");
endmodule // fcc_cycle

//--- fcc_host.sv
// Purpose: Host controller issuing unlock command sequences to a byte-wide flash card
// Assumes: Switch and supply-good levels arrive asynchronously from the card slot
// Notes:   One command at a time; a program cut by supply lockout is replayed
//
// Overview of operation
// - A program cut by lockout is reissued in full after recovery.
// - Enables and write strobe idle high between cycles.
// - Short reset writes F0H to the chip address.
// - Long reset writes AAH, 55H, F0H to first, second, first address.
// - Identifier entry writes AAH, 55H, 90H to command addresses.
// - Byte program is AAH, 55H, A0H, then value to location.
// - Fourth program cycle carries the exact location and value.
// - Sector erase is AAH,55H,80H,AAH,55H then 30H to sector address.
// - Chip erase is the same five writes then 10H to first address.
// - Suspend writes B0H, resume 30H; A21 selects the chip.
`timescale 1ns/1ps
module fcc_host #(
    parameter int RESET_DONE_CYC = fcc_pkg::RESET_DONE_US * fcc_pkg::CLK_MHZ,
    parameter int ERASE_WIN_CYC  = fcc_pkg::ERASE_WINDOW_US * fcc_pkg::CLK_MHZ
) (
    // Clock and reset
    input  wire logic            clock_in,
    input  wire logic            sys_rst_in,
    // Command port
    input  wire logic            cmd_valid_in,
    input  wire fcc_pkg::fcc_op_t cmd_op_in,
    input  wire logic [21:0]     cmd_addr_in,
    input  wire logic [7:0]      cmd_data_in,
    input  wire logic            cmd_lane_in,
    output logic                 cmd_ready_out,
    output logic                 cmd_done_out,
    output logic                 cmd_refused_out,
    output logic [7:0]           read_data_out,
    output logic                 replay_pending_out,
    // Card status levels
    input  wire logic            lockout_switch_in,
    input  wire logic            supply_ok_in,
    // Card pins
    output logic [21:0]          card_addr_out,
    output logic                 low_lane_select_n_out,
    output logic                 high_lane_select_n_out,
    output logic                 card_oe_n_out,
    output logic                 card_we_n_out,
    output logic                 card_reset_n_out,
    output logic [15:0]          card_data_out,
    output logic [1:0]           card_data_oe_out,
    input  wire logic [15:0]     card_data_in
);
    import fcc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ISSUE, ST_BUS, ST_ERASE_WIN, ST_RST_LOW, ST_RST_WAIT
    } fcc_state_t;

    fcc_state_t  state_q, state_d;
    fcc_op_t     op_q;
    logic [21:0] addr_q, save_addr_q;
    logic [7:0]  data_q, save_data_q, rdata_q;
    logic        lane_q, save_lane_q;
    logic [2:0]  step_q;
    logic [CNT_W-1:0] cnt_q;
    logic        replay_q, ready_q, done_q, refused_q, reset_n_q;

    logic [17:0] sync_s;
    logic        eng_done;
    logic [7:0]  eng_rdata;
    logic        eng_lsel_n, eng_hsel_n;

    fcc_sync #(.W(18)) u_sync (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .async_in   ({supply_ok_in, lockout_switch_in, card_data_in}),
        .sync_out   (sync_s)
    );

    wire        supply_ok_s = sync_s[17];
    wire        protect_s   = sync_s[16];
    wire        write_ok    = supply_ok_s && !protect_s;
    wire        cur_write   = !is_read(op_q);
    wire        cmd_write   = !is_read(cmd_op_in) && (cmd_op_in != OP_HW_RESET);
    wire        accept      = (state_q == ST_IDLE) && ready_q && cmd_valid_in;
    wire        refuse      = accept && cmd_write && !write_ok;
    wire        start_cmd   = accept && !refuse;
    wire        replay_go   = (state_q == ST_IDLE) && replay_q && write_ok;
    // Leaving mid-sequence on lockout: card drops it anyway, host does not continue
    wire        abort_now   = cur_write && !supply_ok_s && (state_q == ST_ISSUE);
    wire        eng_start   = (state_q == ST_ISSUE) && !abort_now;
    wire        last_step   = (step_q + 3'd1) == seq_len(op_q);
    wire        cmd_first   = (state_q == ST_BUS) && eng_done && last_step;
    wire [21:0] chip_hi     = {addr_q[CHIP_BIT], 21'h000000};
    wire [21:0] first_a     = CMD_ADDR_FIRST | chip_hi;
    wire [21:0] second_a    = CMD_ADDR_SECOND | chip_hi;
    wire [21:0] eng_addr;
    wire [7:0]  eng_data;

    // Address of the current step
    assign eng_addr =
        (op_q == OP_ID_MAKER)  ? {addr_q[CHIP_BIT], IDENT_MAKER_OFS[20:0]} :
        (op_q == OP_ID_DEVICE) ? {addr_q[CHIP_BIT], IDENT_DEVICE_OFS[20:0]} :
        (seq_len(op_q) == 3'd1) ? addr_q :
        (step_q == 3'd1 || step_q == 3'd4) ? second_a :
        (step_q == 3'd3 && op_q == OP_PROGRAM) ? addr_q :
        (step_q == 3'd5 && op_q == OP_SECT_ERASE) ? addr_q :
        first_a;

    // Data of the current step
    assign eng_data =
        (op_q == OP_RST_SHORT) ? CODE_RESET :
        (op_q == OP_SUSPEND)   ? CODE_SUSPEND :
        (op_q == OP_RESUME)    ? CODE_RESUME :
        (seq_len(op_q) == 3'd1) ? data_q :
        (step_q == 3'd0 || step_q == 3'd3) ?
            ((op_q == OP_PROGRAM && step_q == 3'd3) ? data_q : CODE_UNLOCK1) :
        (step_q == 3'd1 || step_q == 3'd4) ? CODE_UNLOCK2 :
        (step_q == 3'd5) ? ((op_q == OP_SECT_ERASE) ? CODE_SECTOR : CODE_CHIP) :
        (op_q == OP_RST_LONG) ? CODE_RESET :
        (op_q == OP_IDENT)    ? CODE_IDENT :
        (op_q == OP_PROGRAM)  ? CODE_PROGRAM : CODE_ERASE;

    fcc_cycle u_cycle (
        .clock_in               (clock_in),
        .sys_rst_in             (sys_rst_in),
        .start_in               (eng_start),
        .write_in               (cur_write),
        .addr_in                (eng_addr),
        .data_in                (eng_data),
        .lane_in                (lane_q),
        .bus_in                 (sync_s[15:0]),
        .done_out               (eng_done),
        .rdata_out              (eng_rdata),
        .card_addr_out          (card_addr_out),
        .low_lane_select_n_out  (eng_lsel_n),
        .high_lane_select_n_out (eng_hsel_n),
        .card_oe_n_out          (card_oe_n_out),
        .card_we_n_out          (card_we_n_out),
        .card_data_out          (card_data_out),
        .card_data_oe_out       (card_data_oe_out)
    );

    // Lane selects come from engine flops; reset low forces standby via engine idling
    assign low_lane_select_n_out  = eng_lsel_n;
    assign high_lane_select_n_out = eng_hsel_n;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (replay_go || (start_cmd && cmd_op_in != OP_HW_RESET)) begin
                    state_d = ST_ISSUE;
                end else if (start_cmd) begin
                    state_d = ST_RST_LOW;
                end
            end
            ST_ISSUE:     state_d = abort_now ? ST_IDLE : ST_BUS;
            ST_BUS: begin
                if (eng_done && last_step) begin
                    state_d = (op_q == OP_SECT_ERASE) ? ST_ERASE_WIN : ST_IDLE;
                end else if (eng_done) begin
                    state_d = ST_ISSUE;
                end
            end
            ST_ERASE_WIN: if (cnt_q == '0 || !supply_ok_s) state_d = ST_IDLE;
            ST_RST_LOW:   if (cnt_q == '0) state_d = ST_RST_WAIT;
            ST_RST_WAIT:  if (cnt_q == '0) state_d = ST_IDLE;
            default:      state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            // Stay busy on the abort edge too, before the replay flag shows
            ready_q <= (state_d == ST_IDLE) && !replay_q && !replay_go
                       && !(abort_now && op_q == OP_PROGRAM);
            if (state_q != state_d && state_d == ST_ERASE_WIN) begin
                cnt_q <= CNT_W'(ERASE_WIN_CYC - 1);
            end else if (state_q != state_d && state_d == ST_RST_LOW) begin
                cnt_q <= CNT_W'(RESET_LOW_CYC - 1);
            end else if (state_q != state_d && state_d == ST_RST_WAIT) begin
                cnt_q <= CNT_W'(RESET_DONE_CYC - 1);
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            op_q <= OP_READ;
            addr_q <= 22'h000000;
            data_q <= 8'h00;
            lane_q <= 1'b0;
            step_q <= 3'd0;
        end else if (replay_go) begin
            op_q <= OP_PROGRAM;
            addr_q <= save_addr_q;
            data_q <= save_data_q;
            lane_q <= save_lane_q;
            step_q <= 3'd0;
        end else if (start_cmd) begin
            op_q <= cmd_op_in;
            addr_q <= cmd_addr_in;
            data_q <= cmd_data_in;
            lane_q <= cmd_lane_in;
            step_q <= 3'd0;
        end else if (state_q == ST_BUS && eng_done && !last_step) begin
            step_q <= step_q + 3'd1;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            replay_q <= 1'b0;
            save_addr_q <= 22'h000000;
            save_data_q <= 8'h00;
            save_lane_q <= 1'b0;
            done_q <= 1'b0;
            refused_q <= 1'b0;
            rdata_q <= 8'h00;
            reset_n_q <= 1'b1;
        end else begin
            refused_q <= refuse;
            done_q <= cmd_first || (state_q == ST_RST_WAIT && cnt_q == '0)
                      || (state_q == ST_ERASE_WIN && state_d == ST_IDLE);
            reset_n_q <= (state_d != ST_RST_LOW);
            if (cmd_first && is_read(op_q)) begin
                rdata_q <= eng_rdata;
            end
            // Card does not restart an interrupted program, so keep it for reissue
            if (abort_now && op_q == OP_PROGRAM) begin
                replay_q <= 1'b1;
                save_addr_q <= addr_q;
                save_data_q <= data_q;
                save_lane_q <= lane_q;
            end else if (cmd_first && op_q == OP_PROGRAM) begin
                replay_q <= 1'b0;
            end
        end
    end

    assign cmd_ready_out      = ready_q;
    assign cmd_done_out       = done_q;
    assign cmd_refused_out    = refused_q;
    assign read_data_out      = rdata_q;
    assign replay_pending_out = replay_q;
    assign card_reset_n_out   = reset_n_q;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    sequence reset_low_s;
        !reset_n_q [*8];
    endsequence

    protect_refuse_a: assert property (accept && cmd_write && protect_s |=> refused_q && !done_q)
        else $error("write command taken under protect");
    lockout_write_a: assert property (eng_start && cur_write |-> supply_ok_s)
        else $error("write cycle started under lockout");
    replay_kept_a: assert property (abort_now && op_q == OP_PROGRAM |=> replay_q && !ready_q)
        else $error("interrupted program not kept");
    fourth_cycle_a: assert property (eng_start && op_q == OP_PROGRAM && step_q == 3'd3
        |-> eng_addr == addr_q && eng_data == data_q)
        else $error("program data cycle wrong");
    unlock_two_a: assert property (eng_start && seq_len(op_q) > 3'd1 && step_q == 3'd1
        |-> eng_data == CODE_UNLOCK2 && eng_addr[20:0] == CMD_ADDR_SECOND[20:0])
        else $error("second unlock cycle wrong");
    chip_bit_a: assert property (eng_start |-> eng_addr[CHIP_BIT] == addr_q[CHIP_BIT])
        else $error("chip address bit lost");
    erase_window_a: assert property ($rose(state_q == ST_ERASE_WIN) && supply_ok_s
        |-> (state_q == ST_ERASE_WIN) [*4])
        else $error("erase window cut short");
    reset_pulse_a: assert property ($fell(reset_n_q) |-> reset_low_s)
        else $error("card reset pulse too short");
endmodule // fcc_host

//--- fcc_card_model.sv
// Purpose: Behavioural flash card answering the host's card bus
// Assumes: Byte-wide use; one command state for the whole card
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ps
module fcc_card_model #(
    parameter logic [7:0] MAKER = 8'h3C  // Arbitrary value
) (
    // Card pins
    input  wire logic [21:0] card_addr_in,
    input  wire logic        low_lane_select_n_in,
    input  wire logic        high_lane_select_n_in,
    input  wire logic        card_oe_n_in,
    input  wire logic        card_we_n_in,
    input  wire logic [15:0] card_data_in,
    output logic      [15:0] card_data_out,
    // Observation
    output logic      [15:0] writes_out,
    output logic      [21:0] last_addr_out,
    output logic      [7:0]  last_data_out
);
    logic        ident_q = 1'b0;
    logic [15:0] held_q  = 16'h0000;
    wire         sel_w   = !low_lane_select_n_in || !high_lane_select_n_in;
    wire  [7:0]  byte_w  = low_lane_select_n_in ? card_data_in[15:8] : card_data_in[7:0];
    wire  [7:0]  rd_w    = ident_q ? (card_addr_in[0] ? ~MAKER : MAKER) : card_addr_in[7:0];
    initial writes_out = 16'h0000;
    // Data taken at the rising write strobe
    always @(posedge card_we_n_in) begin
        if (sel_w) begin
            writes_out    <= writes_out + 16'h0001;
            last_addr_out <= card_addr_in;
            last_data_out <= byte_w;
            if (byte_w == 8'h90) ident_q <= 1'b1;
            if (byte_w == 8'hF0) ident_q <= 1'b0;
        end
    end
    always @(*) begin
        if (sel_w && !card_oe_n_in) begin
            card_data_out = {rd_w, rd_w};
            held_q        = card_data_out;
        end else begin
            card_data_out = ~held_q;
        end
    end
endmodule // fcc_card_model

//--- fcc_host_tb.sv
// Purpose: Self-checking bench for the flash card host controller
// Assumes: Shortened reset and erase window counts
// Notes:   Random addresses, data and lanes from a fixed seed
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
    $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module fcc_host_tb;
    import fcc_pkg::*;
    logic clock_in = 0, sys_rst_in = 1, cmd_valid_in = 0, cmd_lane_in = 0, got_ref = 0;
    logic lockout_switch_in = 0, supply_ok_in = 1, rdy, done, refd, repl, lsel, hsel, oe, we, rn;
    fcc_op_t cmd_op_in = OP_READ;
    logic [21:0] cmd_addr_in = 0, ca, laddr;
    logic [7:0]  cmd_data_in = 0, rdata, ldata;
    logic [15:0] cdo, cdi, nwr, n0;
    logic [1:0]  doe;
    int bad_count = 0, samples_checked = 0, seed = 45, cycles = 0, rst_low = 0;
    fcc_op_t ops[8] = '{OP_RST_SHORT, OP_RST_LONG, OP_IDENT, OP_PROGRAM, OP_SECT_ERASE,
                        OP_CHIP_ERASE, OP_SUSPEND, OP_RESUME};
    fcc_host #(.RESET_DONE_CYC(20), .ERASE_WIN_CYC(20)) i_fcc_host (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
        .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in), .cmd_lane_in(cmd_lane_in),
        .cmd_ready_out(rdy), .cmd_done_out(done), .cmd_refused_out(refd),
        .read_data_out(rdata), .replay_pending_out(repl), .lockout_switch_in(lockout_switch_in),
        .supply_ok_in(supply_ok_in), .card_addr_out(ca), .low_lane_select_n_out(lsel),
        .high_lane_select_n_out(hsel), .card_oe_n_out(oe), .card_we_n_out(we),
        .card_reset_n_out(rn), .card_data_out(cdo), .card_data_oe_out(doe), .card_data_in(cdi));
    fcc_card_model i_fcc_card_model (.card_addr_in(ca), .low_lane_select_n_in(lsel),
        .high_lane_select_n_in(hsel), .card_oe_n_in(oe), .card_we_n_in(we),
        .card_data_in(cdo), .card_data_out(cdi), .writes_out(nwr), .last_addr_out(laddr),
        .last_data_out(ldata));
    initial forever #2 clock_in = ~clock_in;
    // Pin levels looked at mid-cycle, where they are settled
    always @(negedge clock_in) begin
        if (rn === 1'b0) rst_low++;
        if (oe === 1'b0) `CHK({we, doe}, 3'b100)
    end
    function automatic logic [21:0] exp_a(fcc_op_t op, logic [21:0] a);
        case (op)
            OP_RST_SHORT, OP_PROGRAM, OP_SECT_ERASE, OP_SUSPEND, OP_RESUME: return a;
            default: return CMD_ADDR_FIRST | {a[21], 21'h0};
        endcase
    endfunction
    function automatic int exp_n(fcc_op_t op);
        case (op)
            OP_RST_LONG, OP_IDENT:        return 3;
            OP_PROGRAM:                   return 4;
            OP_SECT_ERASE, OP_CHIP_ERASE: return 6;
            default:                      return 1;
        endcase
    endfunction
    function automatic logic [7:0] exp_d(fcc_op_t op, logic [7:0] d);
        case (op)
            OP_RST_SHORT, OP_RST_LONG: return 8'hF0;
            OP_IDENT:                  return 8'h90;
            OP_PROGRAM:                return d;
            OP_SECT_ERASE, OP_RESUME:  return 8'h30;
            OP_CHIP_ERASE:             return 8'h10;
            default:                   return 8'hB0;
        endcase
    endfunction
    task automatic give_verdict();
        if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic run(fcc_op_t op, logic [21:0] a, logic [7:0] d, logic ln);
        @(posedge clock_in);
        #1;
        cmd_op_in = op; cmd_addr_in = a; cmd_data_in = d; cmd_lane_in = ln; cmd_valid_in = 1;
        n0 = nwr;
        // Ready seen high between edges means the next edge takes the command
        while (rdy !== 1'b1) begin
            @(posedge clock_in);
            #1;
        end
        @(posedge clock_in);
        #1 cmd_valid_in = 0;
        // A refused pulse stands only in the cycle right after the take
        while (done !== 1'b1 && refd !== 1'b1) begin
            @(posedge clock_in);
            #1;
        end
        got_ref = refd;
    endtask
    always @(posedge clock_in) if (++cycles > 90000) begin bad_count++; give_verdict(); end
    initial begin
        repeat (12) @(posedge clock_in);
        #1 sys_rst_in = 0;
        repeat (3) @(posedge clock_in);
        for (int k = 0; k < 16; k++) begin
            run(ops[k % 8], 22'($random(seed)), 8'($random(seed)), 1'($random(seed)));
            `CHK(laddr, exp_a(ops[k % 8], cmd_addr_in))
            `CHK(int'(nwr - n0), exp_n(ops[k % 8]))
            `CHK(ldata, exp_d(ops[k % 8], cmd_data_in))
        end
        run(OP_IDENT, 0, 0, 0); run(OP_ID_MAKER, 0, 0, 0);
        `CHK(rdata, 8'h3C)
        run(OP_ID_DEVICE, 0, 0, 1);
        `CHK(rdata, 8'hC3)
        run(OP_RST_SHORT, 0, 0, 0); run(OP_READ, 22'h00005A, 0, 0);
        `CHK(rdata, 8'h5A)
        lockout_switch_in = 1; repeat (3) @(posedge clock_in);
        run(OP_PROGRAM, 22'h000123, 8'h66, 0);
        `CHK({got_ref, nwr}, {1'b1, n0})
        lockout_switch_in = 0; supply_ok_in = 0; repeat (3) @(posedge clock_in);
        run(OP_RST_SHORT, 0, 0, 0);
        `CHK({got_ref, nwr}, {1'b1, n0})
        supply_ok_in = 1; repeat (3) @(posedge clock_in);
        run(OP_RST_SHORT, 0, 0, 0);
        `CHK(int'(nwr - n0), 1)
        run(OP_HW_RESET, 0, 0, 0);
        `CHK(rst_low, RESET_LOW_CYC)
        // Supply drops during the second program write; the whole program must follow
        fork
            run(OP_PROGRAM, 22'h000321, 8'h77, 0);
            begin
                repeat (24) @(posedge clock_in);
                #1 supply_ok_in = 0;
                repeat (40) @(posedge clock_in);
                #1;
                `CHK({repl, rdy}, 2'b10)
                supply_ok_in = 1;
            end
        join
        `CHK(int'(nwr - n0), 2 + exp_n(OP_PROGRAM))
        `CHK({repl, laddr, ldata}, {1'b0, 22'h000321, 8'h77})
        give_verdict();
    end
endmodule // fcc_host_tb
